// ### fram_port_pkg.sv
// Constants for the bytewide ferroelectric RAM controller.
// Assumes a 50 MHz system clock driving the controller.
package fram_port_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 20;
  // Chip select active (access) time, least.
  localparam int CS_ACTIVE_NS = 70;
  localparam int CS_ACTIVE_CYC =
    (CS_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least precharge time with chip select high.
  localparam int PRECHARGE_TIME_MIN_NS = 60;
  localparam int PRECHARGE_CYC =
    (PRECHARGE_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Write strobe pulse width, least.
  localparam int WSTROBE_NS = 40;
  localparam int WSTROBE_CYC =
    (WSTROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Address hold after chip select falls, least.
  localparam int ADDR_HOLD_NS = 15;
  localparam int ADDR_HOLD_CYC =
    (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // Bytes per endurance row.
  localparam int ROW_BYTES = 8;
  localparam int ROW_SHIFT = 3;
endpackage

// ### fram_port_host.sv
// Host controller that drives a bytewide ferroelectric RAM over its pins.
// Assumes pin inputs are synchronous to CLK and the memory keeps its own
// timing; the data bus level is resolved outside from the enables.
`timescale 1ns/1ns

module fram_port_host #(
  parameter int ACTIVE_CYC = fram_port_pkg::CS_ACTIVE_CYC,
  parameter int PRE_CYC = fram_port_pkg::PRECHARGE_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // User request
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [fram_port_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [fram_port_pkg::DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  // User answer
  output logic RSP_VALID,
  output logic [fram_port_pkg::DATA_W-1:0] RSP_RDATA,
  output logic [fram_port_pkg::ADDR_W-fram_port_pkg::ROW_SHIFT-1:0] RSP_ROW,
  // Memory pins
  output logic MEM_CS_N,
  output logic MEM_WE_N,
  output logic MEM_OE_N,
  output logic [fram_port_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [fram_port_pkg::DATA_W-1:0] MEM_DQ_OUT,
  output logic MEM_DQ_OE,
  input wire logic [fram_port_pkg::DATA_W-1:0] MEM_DQ_IN
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_PRE = 4'h8
  } state_e;

  state_e state;
  logic [fram_port_pkg::CNT_W-1:0] cnt;
  logic is_write;

  // --------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------
  // True in the last cycle of the access, when the answer is formed.
  function automatic logic access_end(input state_e s,
    input logic [fram_port_pkg::CNT_W-1:0] c);
    return (s == ST_ACTIVE) && (c == '0);
  endfunction

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  // SETUP presents address and data one cycle ahead of the chip select
  // edge; the write strobe falls on that same edge, so the cycle is a write
  // from its start and the memory never turns its drivers on.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      cnt <= '0;
      is_write <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (REQ_VALID) begin
            state <= ST_SETUP;
            is_write <= REQ_WRITE;
          end
        end
        ST_SETUP: begin
          state <= ST_ACTIVE;
          cnt <= fram_port_pkg::CNT_W'(ACTIVE_CYC - 1);
        end
        ST_ACTIVE: begin
          // Same length for both kinds of access.
          if (cnt == '0) begin
            state <= ST_PRE;
            cnt <= fram_port_pkg::CNT_W'(PRE_CYC - 1);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_PRE: begin
          if (cnt == '0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MEM_CS_N <= 1'b1;
      MEM_WE_N <= 1'b1;
      MEM_OE_N <= 1'b1;
    end else begin
      case (state)
        ST_SETUP: begin
          MEM_CS_N <= 1'b0;
          MEM_WE_N <= ~is_write;
          MEM_OE_N <= 1'b1;
        end
        ST_ACTIVE: begin
          MEM_CS_N <= (cnt == '0);
          // Strobe rises together with chip select at the end.
          MEM_WE_N <= (cnt == '0) | ~is_write;
          MEM_OE_N <= is_write | (cnt == '0);
        end
        default: begin
          MEM_CS_N <= 1'b1;
          MEM_WE_N <= 1'b1;
          MEM_OE_N <= 1'b1;
        end
      endcase
    end
  end

  // Address and data load in IDLE and stay until the next request. Holding
  // them across the whole cycle covers address hold and data hold at once.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MEM_ADDR <= '0;
      MEM_DQ_OUT <= '0;
      MEM_DQ_OE <= 1'b0;
    end else begin
      if (state == ST_IDLE && REQ_VALID) begin
        MEM_ADDR <= REQ_ADDR;
        MEM_DQ_OUT <= REQ_WDATA;
        MEM_DQ_OE <= REQ_WRITE;
      end else if (state == ST_PRE) begin
        MEM_DQ_OE <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // User side
  // --------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      RSP_ROW <= '0;
    end else begin
      REQ_READY <= (state == ST_PRE && cnt == '0);
      RSP_VALID <= access_end(state, cnt);
      if (access_end(state, cnt)) begin
        // Data is valid after the full access time.
        if (!is_write) begin
          RSP_RDATA <= MEM_DQ_IN;
        end
        RSP_ROW <= MEM_ADDR[fram_port_pkg::ADDR_W-1:fram_port_pkg::ROW_SHIFT];
      end
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_pre_length: assert property (
    @(posedge CLK) disable iff (RST)
    $rose(MEM_CS_N) |-> MEM_CS_N [*3])
    else $error("precharge too short");
  a_active_len: assert property (
    @(posedge CLK) disable iff (RST)
    $fell(MEM_CS_N) |-> !MEM_CS_N [*4] ##1 MEM_CS_N)
    else $error("chip select low time wrong");
  a_addr_stable: assert property (
    @(posedge CLK) disable iff (RST)
    !MEM_CS_N |-> $stable(MEM_ADDR))
    else $error("address moved in cycle");
  a_oe_write: assert property (
    @(posedge CLK) disable iff (RST)
    !MEM_WE_N |-> MEM_OE_N)
    else $error("output enable low during write");
  a_we_before_cs: assert property (
    @(posedge CLK) disable iff (RST)
    $fell(MEM_CS_N) && MEM_DQ_OE |-> !MEM_WE_N)
    else $error("strobe not low at chip select edge");
  a_we_end: assert property (
    @(posedge CLK) disable iff (RST)
    MEM_CS_N |-> MEM_WE_N)
    else $error("strobe low outside chip select");
  a_data_hold: assert property (
    @(posedge CLK) disable iff (RST)
    !MEM_WE_N |-> MEM_DQ_OE && $stable(MEM_DQ_OUT))
    else $error("write data not held");
  a_rsp_timing: assert property (
    @(posedge CLK) disable iff (RST)
    $fell(MEM_CS_N) |-> ##4 RSP_VALID)
    else $error("answer not at end of access");
  a_ready_after: assert property (
    @(posedge CLK) disable iff (RST)
    RSP_VALID |-> ##3 REQ_READY)
    else $error("ready not after precharge");
  // The host must never drive the bus while the memory may drive it.
  a_no_contention: assert property (
    @(posedge CLK) disable iff (RST)
    MEM_DQ_OE |-> MEM_OE_N)
    else $error("data driven while output enabled");
  a_read_strobe: assert property (
    @(posedge CLK) disable iff (RST)
    $fell(MEM_CS_N) && !MEM_DQ_OE |-> MEM_WE_N [*4])
    else $error("strobe low during read");
  a_row_match: assert property (
    @(posedge CLK) disable iff (RST)
    RSP_VALID |-> RSP_ROW ==
      MEM_ADDR[fram_port_pkg::ADDR_W-1:fram_port_pkg::ROW_SHIFT])
    else $error("row index not of this access");
endmodule

// ### fram_dev_model.sv
// Pin-level model of the bytewide ferroelectric RAM.
// Assumes the bench resolves the shared data bus from both enables.
`timescale 1ns/1ns
module fram_dev_model (
  // Memory pins
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [12:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  // Answer speed
  input wire logic slow
);
  logic [7:0] mem [8192];
  int unsigned row_use [1024];
  logic [12:0] held;
  logic is_wr = 1'b0;
  logic wr_open = 1'b0;
  logic valid = 1'b0;
  always @(negedge cs_n) begin
    held = addr;
    is_wr = !we_n;
    wr_open = !we_n;
    row_use[addr[12:3]]++;
    valid = 1'b0;
    valid <= #(slow ? 70 : 5) 1'b1;
  end
  always @(negedge we_n)
    if (!cs_n) begin
      is_wr = 1'b1;
      wr_open = 1'b1;
    end
  // Only the first of the two rising edges closes the write. Both pins may
  // rise in one time step, so an open flag decides, not the pin levels.
  always @(posedge we_n or posedge cs_n)
    if (wr_open) begin
      mem[held] = dq_in;
      wr_open = 1'b0;
    end
  assign dq_oe = !cs_n && !oe_n && !is_wr && valid;
  assign dq_out = mem[held];
endmodule

// ### fram_port_host_tb.sv
// Self-checking bench for the ferroelectric RAM host controller.
// Assumes the pin model above stands on the memory side.
`timescale 1ns/1ns
module fram_port_host_tb;
  typedef struct packed {logic rd; logic [7:0] d; logic [9:0] row;} note_s;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [12:0] REQ_ADDR = 13'h0000;
  logic [7:0] REQ_WDATA = 8'h00;
  logic [7:0] junk = 8'h00;
  logic [7:0] RSP_RDATA, MEM_DQ_OUT, MEM_DQ_IN, dev_out, shadow [8192];
  logic [12:0] MEM_ADDR;
  logic [9:0] RSP_ROW;
  logic REQ_READY, RSP_VALID, MEM_CS_N, MEM_WE_N, MEM_OE_N, MEM_DQ_OE;
  logic dev_oe, slow = 1'b0;
  logic cs_last = 1'b1;
  note_s notes [$];
  note_s nt;
  int error_cnt = 0;
  int checked = 0;
  int run = 0;
  int since = 0;
  int rows [1024];
  fram_port_host fram_port_host_i (.CLK(CLK), .RST(RST),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_RDATA(RSP_RDATA), .RSP_ROW(RSP_ROW), .MEM_CS_N(MEM_CS_N),
    .MEM_WE_N(MEM_WE_N), .MEM_OE_N(MEM_OE_N), .MEM_ADDR(MEM_ADDR),
    .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE(MEM_DQ_OE), .MEM_DQ_IN(MEM_DQ_IN));
  fram_dev_model fram_dev_model_i (.cs_n(MEM_CS_N), .we_n(MEM_WE_N),
    .oe_n(MEM_OE_N), .addr(MEM_ADDR), .dq_in(MEM_DQ_IN), .dq_out(dev_out),
    .dq_oe(dev_oe), .slow(slow));
  // A released bus shows a moving pattern, so early sampling is caught.
  assign MEM_DQ_IN = (MEM_DQ_OE === 1'b1) ? MEM_DQ_OUT :
                     (dev_oe === 1'b1) ? dev_out : junk;
  always @(posedge CLK) junk <= junk + 8'h3b;
  initial forever #10 CLK = ~CLK;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic access(input logic wr, input logic [12:0] a);
    int n;
    note_s x;
    x = '{!wr, wr ? 8'h00 : shadow[a], a[12:3]};
    notes.push_back(x);
    @(posedge CLK);
    #1;
    slow = 1'($urandom);
    REQ_VALID = 1'b1;
    REQ_WRITE = wr;
    REQ_ADDR = a;
    REQ_WDATA = 8'($urandom);
    if (wr) shadow[a] = REQ_WDATA;
    rows[a[12:3]]++;
    n = 0;
    while (MEM_CS_N !== 1'b0 && n < 50) begin @(posedge CLK); #1; n++; end
    // Once taken, the request inputs must no longer matter.
    REQ_ADDR = 13'($urandom);
    REQ_WDATA = 8'($urandom);
    REQ_WRITE = 1'($urandom);
    while (RSP_VALID !== 1'b1 && n < 50) begin @(posedge CLK); #1; n++; end
    if (n >= 50) begin error_cnt++; print_verdict(); end
  endtask
  always @(negedge CLK) begin
    if (MEM_DQ_OE === 1'b1 && dev_oe === 1'b1) chk(16'h1, 16'h0);
    since = (RSP_VALID === 1'b1) ? 0 : since + 1;
    if (REQ_READY === 1'b1)
      chk(16'(since), 16'(fram_port_pkg::PRECHARGE_CYC));
    if (RSP_VALID === 1'b1) begin
      nt = notes.pop_front();
      chk(16'(RSP_ROW), 16'(nt.row));
      if (nt.rd)
        chk(16'(RSP_RDATA), 16'(nt.d));
    end
    if (MEM_CS_N !== cs_last) begin
      if (cs_last === 1'b0)
        chk(16'(run), 16'(fram_port_pkg::CS_ACTIVE_CYC));
      else
        chk(16'(run >= fram_port_pkg::PRECHARGE_CYC), 16'h1);
      run = 0;
    end
    run++;
    cs_last = MEM_CS_N;
  end
  initial begin
    void'($urandom(32'h8cd1));
    repeat (16) @(posedge CLK);
    #1;
    chk(16'(MEM_CS_N), 16'h1);
    RST = 1'b0;
    for (int i = 0; i < 16; i++) access(1'b1, 13'(i));
    access(1'b1, 13'h1000);
    access(1'b1, 13'h1fff);
    for (int i = 0; i < 60; i++)
      access(1'($urandom), 13'($urandom_range(0, 15)));
    access(1'b0, 13'h1000);
    access(1'b0, 13'h1fff);
    access(1'b0, 13'h0000);
    REQ_VALID = 1'b0;
    repeat (12) @(posedge CLK);
    chk(16'(notes.size()), 16'h0);
    // One chip select fall per access, counted against its row.
    for (int r = 0; r < 1024; r++)
      chk(16'(fram_dev_model_i.row_use[r]), 16'(rows[r]));
    print_verdict();
  end
endmodule
